// [verilog/ppb_pkg.sv]
package ppb_pkg;
	localparam logic [7:0] OFF_DIR = 8'h00;
	localparam logic [7:0] OFF_OUT = 8'h04;
	localparam logic [7:0] OFF_PULL = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0C;
	localparam logic [7:0] OFF_EDGE = 8'h10;
	localparam logic [7:0] OFF_PINS = 8'h14;
	localparam logic [7:0] OFF_ISTAT = 8'h18;
	localparam logic [7:0] OFF_IMASK = 8'h1C;
	// Field layout of the port fields in direction, latch and pin registers, and of the pull, mode and edge fields
	localparam int P0_LSB = 0;
	localparam int P1_LSB = 4;
	localparam int P2_LSB = 6;
	localparam int P5_LSB = 12;
	localparam int P6_LSB = 16;
	localparam int PULL_MX_LSB = 8;
	localparam int MODE_AN_LSB = 8;
	localparam int EDGE_FALL_LSB = 4;
	localparam int INT_W = 3;
	// Alternate function positions on the multiplexed port
	localparam int MX_CLK = 0;
	localparam int MX_SOUT = 1;
	localparam int MX_SIN = 2;
	localparam int MX_INT0 = 3;
	localparam int MX_TOUT = 4;
	localparam int MX_TCLK = 5;
	localparam logic [31:0] DIR_MASK = 32'h0000FFFF;
	localparam logic [31:0] OUT_MASK = 32'h0000FFFF;
	localparam logic [31:0] PULL_MASK = 32'h00003F3F;
	localparam logic [31:0] MODE_MASK = 32'h00000F3F;
	localparam logic [31:0] EDGE_MASK = 32'h00000077;
	localparam logic [31:0] INT_MASK = 32'h00000007;
	localparam logic [31:0] REG_RST = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int PULL_NONE = 0;
	localparam int PULL_INPUT = 1;
	localparam int PULL_ALWAYS = 2;
	typedef enum logic [1:0] {PPB_W_IDLE = 2'h1, PPB_W_RESP = 2'h2} ppb_wr_state_type;
	typedef enum logic [1:0] {PPB_R_IDLE = 2'h1, PPB_R_DATA = 2'h2} ppb_rd_state_type;
endpackage : ppb_pkg

// [verilog/ppb_port_drv.sv]
`timescale 1ns/1ps
`default_nettype none
module ppb_port_drv #(
	parameter int WIDTH = 4,
	parameter int PULL_KIND = 1,
	parameter bit OPEN_DRAIN = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] altEn,
	input wire logic [WIDTH-1:0] altVal,
	input wire logic [WIDTH-1:0] pullSel,
	output logic [WIDTH-1:0] pinOut,
	output logic [WIDTH-1:0] pinOe,
	output logic [WIDTH-1:0] pullEn
);
	logic [WIDTH-1:0] out_ff, oe_ff, pull_ff;
	logic [WIDTH-1:0] nxt_out, nxt_oe, nxt_pull, value;
	always_comb begin
		value = (altEn & altVal) | (~altEn & latch);
		if (OPEN_DRAIN) begin
			// Drives low only; a one releases the pin
			nxt_out = '0;
			nxt_oe = dir & ~value;
		end else begin
			nxt_out = value;
			nxt_oe = dir;
		end
		case (PULL_KIND)
			ppb_pkg::PULL_INPUT: nxt_pull = pullSel & ~dir;
			ppb_pkg::PULL_ALWAYS: nxt_pull = pullSel;
			default: nxt_pull = '0;
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_ff <= '0;
			oe_ff <= '0;
			pull_ff <= '0;
		end else begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
			pull_ff <= nxt_pull;
		end
	end
	assign pinOut = out_ff;
	assign pinOe = oe_ff;
	assign pullEn = pull_ff;
endmodule : ppb_port_drv
`default_nettype wire

// [verilog/ppb_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
module ppb_edge_det #(
	parameter int WIDTH = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] level,
	input wire logic [WIDTH-1:0] enable,
	input wire logic [WIDTH-1:0] onRise,
	input wire logic [WIDTH-1:0] onFall,
	output logic [WIDTH-1:0] pulse
);
	logic [WIDTH-1:0] prev_ff, nxt_prev;
	always_comb begin
		nxt_prev = level;
		pulse = enable & ((onRise & level & ~prev_ff) | (onFall & ~level & prev_ff));
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= nxt_prev;
		end
	end
endmodule : ppb_edge_det
`default_nettype wire

// [verilog/ppb_top.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module ppb_top #(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq,
	input wire logic [3:0] firstPortPinsIn,
	output logic [3:0] firstPortPinsOut,
	output logic [3:0] firstPortPinsOe,
	output logic [3:0] firstPortPullEn,
	input wire logic [1:0] secondPortPinsIn,
	output logic [1:0] secondPortPinsOut,
	output logic [1:0] secondPortPinsOe,
	output logic [1:0] secondPortPullEn,
	input wire logic [5:0] multiplexedPortPinsIn,
	output logic [5:0] multiplexedPortPinsOut,
	output logic [5:0] multiplexedPortPinsOe,
	output logic [5:0] multiplexedPortPullEn,
	input wire logic [3:0] openDrainPortPinsIn,
	output logic [3:0] openDrainPortPinsOut,
	output logic [3:0] openDrainPortPinsOe,
	input wire logic [3:0] analogCapableInputPinsIn,
	output logic [3:0] converterAnalogChannels,
	input wire logic syncSerialClockOut,
	input wire logic syncSerialOut,
	input wire logic asyncSerialOut,
	input wire logic serialAsyncMode,
	input wire logic wideTimerOutput,
	input wire logic narrowTimerOutput,
	input wire logic timerOutputWide,
	output logic syncSerialClock,
	output logic asyncSerialClockIn,
	output logic syncSerialIn,
	output logic asyncSerialIn,
	output logic serialChipSelect,
	output logic captureEdgeInput,
	output logic timerCountClockInput
);
	ppb_pkg::ppb_wr_state_type wState_ff, nxt_wState;
	ppb_pkg::ppb_rd_state_type rState_ff, nxt_rState;
	logic awHave_ff, nxt_awHave, wHave_ff, nxt_wHave;
	logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic doWrite;
	logic [31:0] dir_ff, out_ff, pull_ff, mode_ff, edge_ff, istat_ff, imask_ff;
	logic [31:0] nxt_dir, nxt_out, nxt_pull, nxt_mode, nxt_edge, nxt_istat, nxt_imask;
	logic [31:0] pinsNow, istatClr;
	logic [5:0] altIn_ff, nxt_altIn, mxAltVal;
	logic [3:0] anCh_ff, nxt_anCh;
	logic [2:0] intEvent;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st, input logic [31:0] keep);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		merge = ((old & ~m) | (wd & m)) & keep;
	endfunction : merge

	function automatic logic known(input logic [ADDR_W-1:0] a);
		known = (a[1:0] == 2'h0) && (a <= ADDR_W'(ppb_pkg::OFF_IMASK));
	endfunction : known

	// Write channel: address and data are taken in either order
	always_comb begin
		awready = (wState_ff == ppb_pkg::PPB_W_IDLE) && !awHave_ff;
		wready = (wState_ff == ppb_pkg::PPB_W_IDLE) && !wHave_ff;
		bvalid = (wState_ff == ppb_pkg::PPB_W_RESP);
		doWrite = (wState_ff == ppb_pkg::PPB_W_IDLE) && awHave_ff && wHave_ff;
		nxt_wState = wState_ff;
		nxt_awHave = awHave_ff;
		nxt_wHave = wHave_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bresp = bresp_ff;
		if (awvalid && awready) begin
			nxt_awHave = 1'b1;
			nxt_awAddr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_wHave = 1'b1;
			nxt_wData = wdata;
			nxt_wStrb = wstrb;
		end
		case (wState_ff)
			ppb_pkg::PPB_W_IDLE: begin
				if (doWrite) begin
					nxt_awHave = 1'b0;
					nxt_wHave = 1'b0;
					nxt_bresp = known(awAddr_ff) ? ppb_pkg::RESP_OKAY : ppb_pkg::RESP_SLVERR;
					nxt_wState = ppb_pkg::PPB_W_RESP;
				end
			end
			ppb_pkg::PPB_W_RESP: begin
				if (bready) begin
					nxt_wState = ppb_pkg::PPB_W_IDLE;
				end
			end
			default: nxt_wState = ppb_pkg::PPB_W_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wState_ff <= ppb_pkg::PPB_W_IDLE;
			awHave_ff <= 1'b0;
			wHave_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
			bresp_ff <= ppb_pkg::RESP_OKAY;
		end else begin
			wState_ff <= nxt_wState;
			awHave_ff <= nxt_awHave;
			wHave_ff <= nxt_wHave;
			awAddr_ff <= nxt_awAddr;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bresp_ff <= nxt_bresp;
		end
	end
	assign bresp = bresp_ff;

	// Snapshot of the pins; analog-controlled bits read back as zero
	always_comb begin
		pinsNow = 32'h00000000;
		pinsNow[ppb_pkg::P0_LSB +: 4] = firstPortPinsIn;
		pinsNow[ppb_pkg::P1_LSB +: 2] = secondPortPinsIn;
		pinsNow[ppb_pkg::P2_LSB +: 6] = multiplexedPortPinsIn;
		pinsNow[ppb_pkg::P5_LSB +: 4] = openDrainPortPinsIn;
		pinsNow[ppb_pkg::P6_LSB +: 4] = analogCapableInputPinsIn & ~mode_ff[ppb_pkg::MODE_AN_LSB +: 4];
	end

	// Read channel: data is returned the cycle after the address is taken
	always_comb begin
		arready = (rState_ff == ppb_pkg::PPB_R_IDLE);
		rvalid = (rState_ff == ppb_pkg::PPB_R_DATA);
		nxt_rState = rState_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		case (rState_ff)
			ppb_pkg::PPB_R_IDLE: begin
				if (arvalid) begin
					nxt_rState = ppb_pkg::PPB_R_DATA;
					nxt_rresp = known(araddr) ? ppb_pkg::RESP_OKAY : ppb_pkg::RESP_SLVERR;
					case (8'(araddr))
						ppb_pkg::OFF_DIR: nxt_rdata = dir_ff;
						ppb_pkg::OFF_OUT: nxt_rdata = out_ff;
						ppb_pkg::OFF_PULL: nxt_rdata = pull_ff;
						ppb_pkg::OFF_MODE: nxt_rdata = mode_ff;
						ppb_pkg::OFF_EDGE: nxt_rdata = edge_ff;
						ppb_pkg::OFF_PINS: nxt_rdata = pinsNow;
						ppb_pkg::OFF_ISTAT: nxt_rdata = istat_ff;
						ppb_pkg::OFF_IMASK: nxt_rdata = imask_ff;
						default: nxt_rdata = 32'h00000000;
					endcase
				end
			end
			ppb_pkg::PPB_R_DATA: begin
				if (rready) begin
					nxt_rState = ppb_pkg::PPB_R_IDLE;
				end
			end
			default: nxt_rState = ppb_pkg::PPB_R_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rState_ff <= ppb_pkg::PPB_R_IDLE;
			rdata_ff <= 32'h00000000;
			rresp_ff <= ppb_pkg::RESP_OKAY;
		end else begin
			rState_ff <= nxt_rState;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// Configuration, latches and interrupt state
	always_comb begin
		nxt_dir = dir_ff;
		nxt_out = out_ff;
		nxt_pull = pull_ff;
		nxt_mode = mode_ff;
		nxt_edge = edge_ff;
		nxt_imask = imask_ff;
		istatClr = 32'h00000000;
		if (doWrite) begin
			case (8'(awAddr_ff))
				ppb_pkg::OFF_DIR: nxt_dir = merge(dir_ff, wData_ff, wStrb_ff, ppb_pkg::DIR_MASK);
				ppb_pkg::OFF_OUT: nxt_out = merge(out_ff, wData_ff, wStrb_ff, ppb_pkg::OUT_MASK);
				ppb_pkg::OFF_PULL: nxt_pull = merge(pull_ff, wData_ff, wStrb_ff, ppb_pkg::PULL_MASK);
				ppb_pkg::OFF_MODE: nxt_mode = merge(mode_ff, wData_ff, wStrb_ff, ppb_pkg::MODE_MASK);
				ppb_pkg::OFF_EDGE: nxt_edge = merge(edge_ff, wData_ff, wStrb_ff, ppb_pkg::EDGE_MASK);
				ppb_pkg::OFF_ISTAT: istatClr = merge(32'h00000000, wData_ff, wStrb_ff, ppb_pkg::INT_MASK);
				ppb_pkg::OFF_IMASK: nxt_imask = merge(imask_ff, wData_ff, wStrb_ff, ppb_pkg::INT_MASK);
				default: nxt_dir = dir_ff;
			endcase
		end
		// A new edge outweighs a clear in the same cycle
		nxt_istat = (istat_ff & ~istatClr) | {29'h0, intEvent};
		nxt_altIn = multiplexedPortPinsIn & mode_ff[5:0];
		nxt_anCh = analogCapableInputPinsIn & mode_ff[ppb_pkg::MODE_AN_LSB +: 4];
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		// rst is the inverted active-low system reset pin
		if (rst) begin
			dir_ff <= ppb_pkg::REG_RST;
			out_ff <= ppb_pkg::REG_RST;
			pull_ff <= ppb_pkg::REG_RST;
			mode_ff <= ppb_pkg::REG_RST;
			edge_ff <= ppb_pkg::REG_RST;
			istat_ff <= ppb_pkg::REG_RST;
			imask_ff <= ppb_pkg::REG_RST;
			altIn_ff <= 6'h00;
			anCh_ff <= 4'h0;
		end else begin
			dir_ff <= nxt_dir;
			out_ff <= nxt_out;
			pull_ff <= nxt_pull;
			mode_ff <= nxt_mode;
			edge_ff <= nxt_edge;
			istat_ff <= nxt_istat;
			imask_ff <= nxt_imask;
			altIn_ff <= nxt_altIn;
			anCh_ff <= nxt_anCh;
		end
	end
	assign irq = |(istat_ff & imask_ff);
	assign converterAnalogChannels = anCh_ff;
	assign syncSerialClock = altIn_ff[ppb_pkg::MX_CLK];
	assign asyncSerialClockIn = altIn_ff[ppb_pkg::MX_CLK];
	assign syncSerialIn = altIn_ff[ppb_pkg::MX_SIN];
	assign asyncSerialIn = altIn_ff[ppb_pkg::MX_SIN];
	assign serialChipSelect = altIn_ff[ppb_pkg::MX_INT0];
	assign captureEdgeInput = altIn_ff[ppb_pkg::MX_INT0];
	assign timerCountClockInput = altIn_ff[ppb_pkg::MX_TCLK];

	// Peripheral values driven onto control-mode pins; input-only functions stay at the latch-free zero
	always_comb begin
		mxAltVal = 6'h00;
		mxAltVal[ppb_pkg::MX_CLK] = syncSerialClockOut;
		mxAltVal[ppb_pkg::MX_SOUT] = serialAsyncMode ? asyncSerialOut : syncSerialOut;
		mxAltVal[ppb_pkg::MX_TOUT] = timerOutputWide ? wideTimerOutput : narrowTimerOutput;
	end

	ppb_edge_det #(.WIDTH(ppb_pkg::INT_W)) u_edge (
		.ref_clk(ref_clk),
		.rst(rst),
		.level(multiplexedPortPinsIn[ppb_pkg::MX_INT0 +: 3]),
		.enable(mode_ff[ppb_pkg::MX_INT0 +: 3]),
		.onRise(edge_ff[2:0]),
		.onFall(edge_ff[ppb_pkg::EDGE_FALL_LSB +: 3]),
		.pulse(intEvent)
	);
	ppb_port_drv #(.WIDTH(4), .PULL_KIND(ppb_pkg::PULL_INPUT), .OPEN_DRAIN(1'b0)) u_port0 (
		.ref_clk(ref_clk),
		.rst(rst),
		.latch(out_ff[ppb_pkg::P0_LSB +: 4]),
		.dir(dir_ff[ppb_pkg::P0_LSB +: 4]),
		.altEn(4'h0),
		.altVal(4'h0),
		.pullSel(pull_ff[ppb_pkg::P0_LSB +: 4]),
		.pinOut(firstPortPinsOut),
		.pinOe(firstPortPinsOe),
		.pullEn(firstPortPullEn)
	);
	ppb_port_drv #(.WIDTH(2), .PULL_KIND(ppb_pkg::PULL_INPUT), .OPEN_DRAIN(1'b0)) u_port1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.latch(out_ff[ppb_pkg::P1_LSB +: 2]),
		.dir(dir_ff[ppb_pkg::P1_LSB +: 2]),
		.altEn(2'h0),
		.altVal(2'h0),
		.pullSel(pull_ff[ppb_pkg::P1_LSB +: 2]),
		.pinOut(secondPortPinsOut),
		.pinOe(secondPortPinsOe),
		.pullEn(secondPortPullEn)
	);
	// Control-mode pins keep their direction bit, so software must set it for the chosen serial mode
	ppb_port_drv #(.WIDTH(6), .PULL_KIND(ppb_pkg::PULL_ALWAYS), .OPEN_DRAIN(1'b0)) u_port2 (
		.ref_clk(ref_clk),
		.rst(rst),
		.latch(out_ff[ppb_pkg::P2_LSB +: 6]),
		.dir(dir_ff[ppb_pkg::P2_LSB +: 6]),
		.altEn(mode_ff[5:0]),
		.altVal(mxAltVal),
		.pullSel(pull_ff[ppb_pkg::PULL_MX_LSB +: 6]),
		.pinOut(multiplexedPortPinsOut),
		.pinOe(multiplexedPortPinsOe),
		.pullEn(multiplexedPortPullEn)
	);
	ppb_port_drv #(.WIDTH(4), .PULL_KIND(ppb_pkg::PULL_NONE), .OPEN_DRAIN(1'b1)) u_port5 (
		.ref_clk(ref_clk),
		.rst(rst),
		.latch(out_ff[ppb_pkg::P5_LSB +: 4]),
		.dir(dir_ff[ppb_pkg::P5_LSB +: 4]),
		.altEn(4'h0),
		.altVal(4'h0),
		.pullSel(4'h0),
		.pinOut(openDrainPortPinsOut),
		.pinOe(openDrainPortPinsOe),
		.pullEn()
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_firstDir;
		doWrite && (8'(awAddr_ff) == ppb_pkg::OFF_DIR) && wStrb_ff[0] |=> ##1 firstPortPinsOe == $past(wData_ff[3:0], 2);
	endproperty
	a_firstDir: assert property (p_firstDir) else $error("first port direction not applied");
	property p_sharedPull;
		{secondPortPullEn, firstPortPullEn} == ($past(pull_ff[5:0]) & ~$past(dir_ff[5:0]));
	endproperty
	a_sharedPull: assert property (p_sharedPull) else $error("shared pull-up wrong");
	property p_secondDir;
		$changed(dir_ff[5:4]) |=> secondPortPinsOe == $past(dir_ff[5:4]);
	endproperty
	a_secondDir: assert property (p_secondDir) else $error("second port direction wrong");
	property p_muxPort;
		(mode_ff[5:0] == 6'h00) ##1 (mode_ff[5:0] == 6'h00) |->
			multiplexedPortPinsOut == $past(out_ff[11:6]) && multiplexedPortPinsOe == $past(dir_ff[11:6]);
	endproperty
	a_muxPort: assert property (p_muxPort) else $error("multiplexed port mode wrong");
	property p_muxPull;
		multiplexedPortPullEn == $past(pull_ff[13:8]);
	endproperty
	a_muxPull: assert property (p_muxPull) else $error("multiplexed pull-up wrong");
	property p_altOut;
		mode_ff[1] && serialAsyncMode |=> multiplexedPortPinsOut[1] == $past(asyncSerialOut);
	endproperty
	a_altOut: assert property (p_altOut) else $error("control mode output wrong");
	property p_edgeSets;
		intEvent != 3'h0 |=> (istat_ff[2:0] & $past(intEvent)) == $past(intEvent);
	endproperty
	a_edgeSets: assert property (p_edgeSets) else $error("edge event lost");
	property p_openDrain;
		openDrainPortPinsOut == 4'h0 && openDrainPortPinsOe == ($past(dir_ff[15:12]) & ~$past(out_ff[15:12]));
	endproperty
	a_openDrain: assert property (p_openDrain) else $error("open-drain drive wrong");
	property p_analog;
		converterAnalogChannels == ($past(analogCapableInputPinsIn) & $past(mode_ff[11:8]));
	endproperty
	a_analog: assert property (p_analog) else $error("analog routing wrong");
	property p_resetIn;
		$past(rst) |-> {firstPortPinsOe, secondPortPinsOe, multiplexedPortPinsOe, openDrainPortPinsOe} == 16'h0000;
	endproperty
	a_resetIn: assert property (p_resetIn) else $error("pin driven after reset");
	c_write: cover property (doWrite ##[1:4] (bvalid && bready));
	c_irq: cover property ((intEvent != 3'h0) ##1 irq);
	c_analog: cover property (converterAnalogChannels != 4'h0);
endmodule : ppb_top
`default_nettype wire

// [verification/ppb_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ppb_board_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] dOut,
	input wire logic [15:0] dOe,
	input wire logic [15:0] dPull,
	input wire logic [15:0] extEn,
	input wire logic [15:0] extVal,
	output logic [15:0] pinLvl
);
	logic [15:0] drift_ff;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			drift_ff <= 16'h5555;
		end else begin
			drift_ff <= ~drift_ff;
		end
	end
	// A released pin with no pull-up and no external drive wanders, so a stale level is never read back as valid
	assign pinLvl = (dOe & dOut) | (~dOe & extEn & extVal) | (~dOe & ~extEn & (dPull | drift_ff));
endmodule : ppb_board_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
	localparam logic [15:0] D = 16'hA6E5;
	localparam logic [15:0] L = 16'h3C96;
	localparam logic [15:0] E = 16'h6B1D;
	logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, secondPortPinsIn, secondPortPinsOut, secondPortPinsOe, secondPortPullEn;
	logic [3:0] firstPortPinsIn, firstPortPinsOut, firstPortPinsOe, firstPortPullEn;
	logic [5:0] multiplexedPortPinsIn, multiplexedPortPinsOut, multiplexedPortPinsOe, multiplexedPortPullEn;
	logic [3:0] openDrainPortPinsIn, openDrainPortPinsOut, openDrainPortPinsOe;
	logic [3:0] analogCapableInputPinsIn, converterAnalogChannels;
	logic syncSerialClockOut, syncSerialOut, asyncSerialOut, serialAsyncMode, wideTimerOutput, narrowTimerOutput;
	logic timerOutputWide, syncSerialClock, asyncSerialClockIn, syncSerialIn, asyncSerialIn, serialChipSelect;
	logic captureEdgeInput, timerCountClockInput;
	logic [15:0] extEn, extVal, pinLvl;
	int fails, checksDone;
	always #2.5 ref_clk = ~ref_clk;
	assign {openDrainPortPinsIn, multiplexedPortPinsIn, secondPortPinsIn, firstPortPinsIn} = pinLvl;
	ppb_top #(.ADDR_W(8)) i_dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
		.firstPortPinsIn, .firstPortPinsOut, .firstPortPinsOe, .firstPortPullEn, .secondPortPinsIn,
		.secondPortPinsOut, .secondPortPinsOe, .secondPortPullEn, .multiplexedPortPinsIn, .multiplexedPortPinsOut,
		.multiplexedPortPinsOe, .multiplexedPortPullEn, .openDrainPortPinsIn, .openDrainPortPinsOut,
		.openDrainPortPinsOe, .analogCapableInputPinsIn, .converterAnalogChannels, .syncSerialClockOut,
		.syncSerialOut, .asyncSerialOut, .serialAsyncMode, .wideTimerOutput, .narrowTimerOutput, .timerOutputWide,
		.syncSerialClock, .asyncSerialClockIn, .syncSerialIn, .asyncSerialIn, .serialChipSelect, .captureEdgeInput,
		.timerCountClockInput);
	ppb_board_model i_board (.ref_clk, .rst, .extEn, .extVal, .pinLvl,
		.dOut({openDrainPortPinsOut, multiplexedPortPinsOut, secondPortPinsOut, firstPortPinsOut}),
		.dOe({openDrainPortPinsOe, multiplexedPortPinsOe, secondPortPinsOe, firstPortPinsOe}),
		.dPull({4'h0, multiplexedPortPullEn, secondPortPullEn, firstPortPullEn}));
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : wt
	// Both bus tasks start on a rising edge and return at a falling edge once the response has been seen
	task automatic axW(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, pa, pw, hb;
		pa = 1'b1;
		pw = 1'b1;
		hb = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge ref_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge ref_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		bready <= 1'b1;
		while (!hb) begin
			@(negedge ref_clk);
			hb = bvalid;
			rs = bresp;
			@(posedge ref_clk);
		end
		bready <= 1'b0;
		@(negedge ref_clk);
	endtask : axW
	task automatic axR(input logic [7:0] a);
		logic ta, hr;
		hr = 1'b0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr) begin
			@(negedge ref_clk);
			ta = arvalid && arready;
			hr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge ref_clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(negedge ref_clk);
	endtask : axR
	task automatic chkRst;
		`CHK({firstPortPinsOe, secondPortPinsOe, multiplexedPortPinsOe, openDrainPortPinsOe}, 16'h0000)
		`CHK({firstPortPullEn, secondPortPullEn, multiplexedPortPullEn}, 12'h000)
		`CHK({awready, wready, arready, bvalid, rvalid, irq}, 6'h38)
		axR(ppb_pkg::OFF_DIR);
		`CHK(rd, 32'h00000000)
		`CHK(rs, ppb_pkg::RESP_OKAY)
		axR(ppb_pkg::OFF_PULL);
		`CHK(rd, 32'h00000000)
	endtask : chkRst
	task automatic scnPins;
		logic [15:0] lv;
		lv = (D & L) | (~D & E);
		lv[15:12] = E[15:12] & ~(D[15:12] & ~L[15:12]);
		axW(ppb_pkg::OFF_OUT, {16'h0000, L});
		axW(ppb_pkg::OFF_DIR, {16'h0000, D});
		`CHK(rs, ppb_pkg::RESP_OKAY)
		`CHK(firstPortPinsOe, D[3:0])
		`CHK(secondPortPinsOe, D[5:4])
		`CHK(multiplexedPortPinsOe, D[11:6])
		`CHK(openDrainPortPinsOe, D[15:12] & ~L[15:12])
		`CHK(openDrainPortPinsOut, 4'h0)
		axR(ppb_pkg::OFF_PINS);
		`CHK(rd[11:0], lv[11:0])
		`CHK(rd[15:12], lv[15:12])
		`CHK(rd[19:16], 4'h9)
	endtask : scnPins
	task automatic scnPull;
		axW(ppb_pkg::OFF_PULL, 32'h0000153F);
		@(posedge ref_clk);
		extEn <= 16'hFFF0;
		wt(2);
		`CHK(firstPortPullEn, ~D[3:0])
		`CHK(secondPortPullEn, ~D[5:4])
		`CHK(multiplexedPortPullEn, 6'h15)
		axR(ppb_pkg::OFF_PINS);
		`CHK(rd[3:0], L[3:0] | ~D[3:0])
		@(posedge ref_clk);
		extEn <= 16'hFFFF;
	endtask : scnPull
	task automatic scnAnalog;
		@(posedge ref_clk);
		analogCapableInputPinsIn <= 4'hF;
		axW(ppb_pkg::OFF_MODE, 32'h00000600);
		`CHK(converterAnalogChannels, 4'h6)
		axR(ppb_pkg::OFF_PINS);
		`CHK(rd[19:16], 4'h9)
	endtask : scnAnalog
	task automatic scnAlt;
		int m;
		@(posedge ref_clk);
		extVal <= 16'hFFFF;
		axW(ppb_pkg::OFF_MODE, 32'h00000000);
		axW(ppb_pkg::OFF_DIR, 32'h00000480);
		`CHK(timerCountClockInput, 1'b0)
		axW(ppb_pkg::OFF_MODE, 32'h0000003F);
		for (m = 0; m < 2; m++) begin
			@(posedge ref_clk);
			serialAsyncMode <= m[0];
			timerOutputWide <= m[0];
			syncSerialOut <= ~m[0];
			asyncSerialOut <= m[0];
			narrowTimerOutput <= ~m[0];
			wideTimerOutput <= m[0];
			wt(3);
			`CHK(multiplexedPortPinsOut[1], 1'b1)
			`CHK(multiplexedPortPinsOut[4], 1'b1)
			`CHK({timerCountClockInput, captureEdgeInput, serialChipSelect}, 3'h7)
			`CHK(m ? {asyncSerialClockIn, asyncSerialIn} : {syncSerialClock, syncSerialIn}, 2'h3)
		end
	endtask : scnAlt
	task automatic scnIrq;
		axW(ppb_pkg::OFF_DIR, 32'h00000000);
		axW(ppb_pkg::OFF_EDGE, 32'h00000065);
		axW(ppb_pkg::OFF_IMASK, 32'h00000007);
		axR(ppb_pkg::OFF_EDGE);
		`CHK(rd, 32'h00000065)
		@(posedge ref_clk);
		extVal[11:9] <= 3'h0;
		wt(4);
		axW(ppb_pkg::OFF_ISTAT, 32'h00000007);
		`CHK(irq, 1'b0)
		@(posedge ref_clk);
		extVal[11:9] <= 3'h7;
		wt(4);
		`CHK(irq, 1'b1)
		axR(ppb_pkg::OFF_ISTAT);
		`CHK(rd[2:0], 3'h5)
		axW(ppb_pkg::OFF_ISTAT, 32'h00000007);
		@(posedge ref_clk);
		extVal[11:9] <= 3'h0;
		wt(4);
		axR(ppb_pkg::OFF_ISTAT);
		`CHK(rd[2:0], 3'h6)
		axW(ppb_pkg::OFF_IMASK, 32'h00000000);
		`CHK(irq, 1'b0)
		axW(ppb_pkg::OFF_ISTAT, 32'h00000007);
		axR(ppb_pkg::OFF_ISTAT);
		`CHK(rd[2:0], 3'h0)
	endtask : scnIrq
	task automatic scnErr;
		axR(8'h20);
		`CHK(rs, ppb_pkg::RESP_SLVERR)
		`CHK(rd, 32'h00000000)
		axR(8'h02);
		`CHK(rs, ppb_pkg::RESP_SLVERR)
		axW(8'h24, 32'hFFFFFFFF);
		`CHK(rs, ppb_pkg::RESP_SLVERR)
	endtask : scnErr
	task automatic scnReset;
		axW(ppb_pkg::OFF_DIR, 32'h0000FFFF);
		@(posedge ref_clk);
		rst <= 1'b1;
		wt(2);
		`CHK({firstPortPinsOe, secondPortPinsOe, multiplexedPortPinsOe, openDrainPortPinsOe}, 16'h0000)
		@(posedge ref_clk);
		rst <= 1'b0;
		wt(1);
		chkRst();
	endtask : scnReset
	task results;
		if (fails == 0 && checksDone > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{serialAsyncMode, timerOutputWide, syncSerialClockOut, syncSerialOut} = 4'h0;
		{asyncSerialOut, wideTimerOutput, narrowTimerOutput} = 3'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		extEn = 16'hFFFF;
		extVal = E;
		analogCapableInputPinsIn = 4'h9;
		fails = 0;
		checksDone = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		wt(1);
		chkRst();
		scnPins();
		scnPull();
		scnAnalog();
		scnAlt();
		scnIrq();
		scnErr();
		scnReset();
		results();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		results();
	end
endmodule : tb
`default_nettype wire
